/* core/fsp_ctrl.sv */
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`include "fsp_params.svh"
// Contract
// - re-enable with store enable, then store within four cycles, makes section readable.
// - no section re-enable while an erase or write still runs.
// - re-enable written during buffer loading aborts the load, drops buffered data.
// - lock set with store enable, store within four cycles programs lock from low data.
// - lock set bit clears on completion or after four cycles without a store.
// - load within three cycles after lock set returns lock or fuse bits.
// - page write with store enable, store within four cycles writes buffer to page.
// - page write bit clears on completion or after four idle cycles.
// - page erase with store enable erases pointer page; clears on completion or timeout.
// - erase or write to halting section halts the CPU throughout.
// - erase or write to readable section keeps halting section readable.
// - store enable alone stores high:low data at pointer word, LSB ignored.
// - store enable clears after a store or four idle cycles; held during operations.
// - only five command codes in the low bits take effect.
// - flash address is latched at operation start.
// - buffer clears after page write, re-enable write, and system reset.
// - eeprom write during page loading discards the buffered data.
// - enabled ready interrupt stands as long as store enable is clear.
// - busy flag stays set and section reads blocked while section is busy.
// - busy flag clears on re-enable after programming or when page loading starts.
module fsp_ctrl (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`FSP_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // cpu instruction side
  input wire logic store_instr_i,
  input wire logic load_instr_i,
  input wire logic [`FSP_PTR_MSB:0] pointer_i,
  input wire logic [7:0] data_low_register_i,
  input wire logic [7:0] data_high_register_i,
  output logic [7:0] load_data_o,
  output logic load_valid_o,
  output logic cpu_halt_o,
  output logic section_read_block_o,
  output logic ready_irq_o,
  // eeprom activity
  input wire logic eeprom_write_i,
  // lock and fuse values
  input wire logic [7:0] lock_bits_i,
  input wire logic [7:0] fuse_low_i,
  input wire logic [7:0] fuse_high_i,
  input wire logic [7:0] fuse_ext_i,
  // flash array
  output logic flash_start_o,
  output fsp_pkg::fsp_op_type flash_op_o,
  output logic [`FSP_PAGE_BITS-1:0] flash_page_o,
  output logic [7:0] flash_lock_data_o,
  input wire logic flash_done_i,
  input wire logic [`FSP_WORD_BITS-1:0] buf_index_i,
  output logic [`FSP_WORD_W-1:0] buf_word_o
);
  import fsp_pkg::*;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic fsp_code_ok(input logic [4:0] code);
    return (code == `FSP_CODE_STORE) || (code == `FSP_CODE_ERASE) ||
           (code == `FSP_CODE_WRITE) || (code == `FSP_CODE_LOCK) ||
           (code == `FSP_CODE_REENABLE);
  endfunction

  function automatic logic fsp_long_op(input logic [4:0] code);
    return (code == `FSP_CODE_ERASE) || (code == `FSP_CODE_WRITE) ||
           (code == `FSP_CODE_LOCK);
  endfunction

  fsp_state_type state;
  fsp_state_type next_state;
  logic [4:0] cmd;
  logic irq_en;
  logic section_busy;
  logic op_halt;
  logic wb_hit;
  logic ctrl_write;
  logic ctrl_accept;
  logic store_go;
  logic load_go;
  logic tmr_open;
  logic tmr_expire;
  logic [`FSP_CNT_W-1:0] tmr_count;
  logic buf_loaded;
  logic buf_clear;
  logic buf_wr;
  logic op_done;
  logic page_op;
  logic [`FSP_PAGE_BITS-1:0] ptr_page;
  logic halt_target;
  logic [7:0] ctrl_readback;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  assign wb_hit = cyc_i & stb_i & ~ack_o;
  assign ctrl_write = wb_hit & we_i & sel_i[0] & (adr_i == `FSP_ADDR_CONTROL);
  // writes while busy leave the command bits alone: no re-enable mid-operation
  assign ctrl_accept = ctrl_write && (state != FSP_BUSY) && fsp_code_ok(dat_i[4:0]);
  assign store_go = store_instr_i && !ctrl_write && (state == FSP_ARMED) && tmr_open;
  assign load_go = load_instr_i && !ctrl_write && (state == FSP_ARMED) && tmr_open &&
                   (tmr_count < `FSP_LOAD_LIMIT) && (cmd == `FSP_CODE_LOCK);
  assign op_done = (state == FSP_BUSY) && flash_done_i;
  assign page_op = (cmd == `FSP_CODE_ERASE) || (cmd == `FSP_CODE_WRITE);
  assign ptr_page = pointer_i[`FSP_PTR_MSB:`FSP_WORD_BITS+1];
  assign halt_target = (ptr_page >= `FSP_HALT_FIRST_PAGE);

  fsp_window_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(ctrl_accept),
    .stop_i(store_go || load_go),
    .open_o(tmr_open),
    .count_o(tmr_count),
    .expire_o(tmr_expire)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    if (ctrl_accept) begin
      next_state = FSP_ARMED;
    end else begin
      unique case (state)
        FSP_IDLE: begin
          next_state = FSP_IDLE;
        end
        FSP_ARMED: begin
          if (load_go || tmr_expire) begin
            next_state = FSP_IDLE;
          end else if (store_go) begin
            next_state = fsp_long_op(cmd) ? FSP_BUSY : FSP_IDLE;
          end
        end
        FSP_BUSY: begin
          if (flash_done_i) begin
            next_state = FSP_IDLE;
          end
        end
        default: begin
          next_state = FSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= FSP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // command bits, store enable included, stay set through a long operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd <= `FSP_CTRL_RESET;
    end else if (ctrl_accept) begin
      cmd <= dat_i[4:0];
    end else if (tmr_expire || load_go) begin
      cmd <= `FSP_CTRL_RESET;
    end else if (store_go && !fsp_long_op(cmd)) begin
      cmd <= `FSP_CTRL_RESET;
    end else if (op_done) begin
      cmd <= `FSP_CTRL_RESET;
    end
  end

  // enable bit is written on every control write, even an ignored code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= 1'b0;
    end else if (ctrl_write) begin
      irq_en <= dat_i[`FSP_BIT_IRQ_EN];
    end
  end

  // ----------------------------------------
  // section state and halting
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      section_busy <= 1'b0;
    end else if (store_go && page_op && !halt_target) begin
      section_busy <= 1'b1;
    end else if (store_go && (cmd == `FSP_CODE_REENABLE)) begin
      section_busy <= 1'b0;
    end else if (store_go && (cmd == `FSP_CODE_STORE)) begin
      section_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_halt <= 1'b0;
    end else if (store_go && page_op) begin
      op_halt <= halt_target;
    end else if (op_done) begin
      op_halt <= 1'b0;
    end
  end

  assign cpu_halt_o = op_halt;
  assign section_read_block_o = section_busy;
  assign ready_irq_o = irq_en & ~cmd[`FSP_BIT_STORE_EN];

  // ----------------------------------------
  // flash array command
  // ----------------------------------------
  // page and lock data are captured once, so the pointer is free afterwards
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_start_o <= 1'b0;
      flash_op_o <= FSP_OP_NONE;
      flash_page_o <= '0;
      flash_lock_data_o <= '0;
    end else begin
      flash_start_o <= store_go && fsp_long_op(cmd);
      if (store_go && (cmd == `FSP_CODE_ERASE)) begin
        flash_op_o <= FSP_OP_ERASE;
        flash_page_o <= ptr_page;
      end else if (store_go && (cmd == `FSP_CODE_WRITE)) begin
        flash_op_o <= FSP_OP_WRITE;
        flash_page_o <= ptr_page;
      end else if (store_go && (cmd == `FSP_CODE_LOCK)) begin
        flash_op_o <= FSP_OP_LOCK;
        flash_lock_data_o <= data_low_register_i;
      end else if (op_done) begin
        flash_op_o <= FSP_OP_NONE;
      end
    end
  end

  // ----------------------------------------
  // temporary page buffer
  // ----------------------------------------
  assign buf_wr = store_go && (cmd == `FSP_CODE_STORE);
  assign buf_clear = (ctrl_accept && (dat_i[4:0] == `FSP_CODE_REENABLE)) ||
                     eeprom_write_i ||
                     (op_done && (flash_op_o == FSP_OP_WRITE));

  fsp_page_buffer u_buffer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(buf_clear),
    .wr_i(buf_wr),
    .wr_index_i(pointer_i[`FSP_WORD_BITS:1]),
    .wr_data_i({data_high_register_i, data_low_register_i}),
    .rd_index_i(buf_index_i),
    .rd_data_o(buf_word_o),
    .loaded_o(buf_loaded)
  );

  // ----------------------------------------
  // lock and fuse readback
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_valid_o <= 1'b0;
      load_data_o <= '0;
    end else begin
      load_valid_o <= load_go;
      if (load_go) begin
        unique case (pointer_i[1:0])
          `FSP_SEL_FUSE_LOW: load_data_o <= fuse_low_i;
          `FSP_SEL_LOCK: load_data_o <= lock_bits_i;
          `FSP_SEL_FUSE_EXT: load_data_o <= fuse_ext_i;
          `FSP_SEL_FUSE_HIGH: load_data_o <= fuse_high_i;
        endcase
      end
    end
  end

  // ----------------------------------------
  // wishbone answer
  // ----------------------------------------
  assign ctrl_readback = {irq_en, section_busy, 1'b0, cmd};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= wb_hit;
      if (wb_hit && !we_i && (adr_i == `FSP_ADDR_CONTROL)) begin
        dat_o <= 32'(ctrl_readback);
      end else begin
        dat_o <= '0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_window_close: assert property (ctrl_accept ##1
    (!store_instr_i && !load_instr_i && !ctrl_write)[*4] |=> cmd == `FSP_CTRL_RESET)
    else $error("command window did not close after four idle cycles");
  a_store_held: assert property ((state == FSP_BUSY) |-> cmd[`FSP_BIT_STORE_EN])
    else $error("store enable dropped during an operation");
  a_busy_keeps: assert property ((state == FSP_BUSY && section_busy) |=> section_busy)
    else $error("section re-enabled while operation in progress");
  a_reenable_clear: assert property ((store_go && cmd == `FSP_CODE_REENABLE) |=>
    !section_busy && !section_read_block_o)
    else $error("re-enable store left section blocked");
  a_halt_only_busy: assert property (cpu_halt_o |-> (state == FSP_BUSY) &&
    (flash_page_o >= `FSP_HALT_FIRST_PAGE))
    else $error("cpu halted outside a halting operation");
  a_halt_start: assert property ((store_go && page_op && halt_target) |=> cpu_halt_o)
    else $error("halting page operation did not halt the cpu");
  a_page_split: assert property ((store_go && page_op && !halt_target) |=>
    section_busy && !cpu_halt_o)
    else $error("readable page operation halted the cpu or left the section open");
  a_addr_latched: assert property ((state == FSP_BUSY && $past(state) == FSP_BUSY) |->
    $stable(flash_page_o))
    else $error("latched page changed during operation");
  a_write_clears: assert property ((op_done && flash_op_o == FSP_OP_WRITE) |=> !buf_loaded)
    else $error("buffer not cleared after page write");
  a_eeprom_drop: assert property (eeprom_write_i |=> !buf_loaded)
    else $error("buffer kept data across eeprom write");
  a_load_return: assert property (load_go |=> load_valid_o && cmd == `FSP_CTRL_RESET)
    else $error("load did not return lock or fuse data");
  a_bad_code: assert property ((ctrl_write && !fsp_code_ok(dat_i[4:0]) && !store_go &&
    !load_go && !tmr_expire && !op_done) |=> $stable(cmd))
    else $error("invalid command code changed command bits");
  a_irq_level: assert property ((op_done && irq_en && !ctrl_write) |=> ready_irq_o)
    else $error("ready interrupt missing after the operation finished");

  c_page_write: cover property (store_go && cmd == `FSP_CODE_WRITE ##[1:100] op_done);
  c_lock_read: cover property (load_go);
  c_timeout: cover property (tmr_expire);
  c_halting_op: cover property ($rose(cpu_halt_o));
endmodule

/* core/fsp_page_buffer.sv */
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_page_buffer (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // load side
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [`FSP_WORD_BITS-1:0] wr_index_i,
  input wire logic [`FSP_WORD_W-1:0] wr_data_i,
  // drain side
  input wire logic [`FSP_WORD_BITS-1:0] rd_index_i,
  output logic [`FSP_WORD_W-1:0] rd_data_o,
  output logic loaded_o
);
  import fsp_pkg::*;

  logic [`FSP_WORD_W-1:0] mem [`FSP_PAGE_WORDS];

  // discard wins over a write in the same cycle: the load is being thrown away
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      for (int i = 0; i < `FSP_PAGE_WORDS; i++) begin
        mem[i] <= `FSP_ERASED_WORD;
      end
    end else if (wr_i) begin
      mem[wr_index_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      loaded_o <= 1'b0;
    end else if (wr_i) begin
      loaded_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= `FSP_ERASED_WORD;
    end else begin
      rd_data_o <= mem[rd_index_i];
    end
  end
endmodule

/* core/fsp_window_timer.sv */
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_window_timer (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic stop_i,
  // status
  output logic open_o,
  output logic [`FSP_CNT_W-1:0] count_o,
  output logic expire_o
);
  import fsp_pkg::*;

  logic last;

  assign last = (count_o == `FSP_STORE_LAST);
  // a restart in the final cycle wins, so a rewrite never looks like a timeout
  assign expire_o = open_o & last & ~start_i & ~stop_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_o <= 1'b0;
      count_o <= `FSP_CNT_ZERO;
    end else if (start_i) begin
      open_o <= 1'b1;
      count_o <= `FSP_CNT_ZERO;
    end else if (stop_i || expire_o) begin
      open_o <= 1'b0;
    end else if (open_o) begin
      count_o <= count_o + `FSP_CNT_ONE;
    end
  end
endmodule

/* include/fsp_params.svh */
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// ----------------------------------------
// register map and control field layout
// ----------------------------------------
`define FSP_ADR_W 8
`define FSP_ADDR_CONTROL 8'h68
`define FSP_CTRL_RESET 5'h00
`define FSP_BIT_IRQ_EN 7
`define FSP_BIT_STORE_EN 0
`define FSP_CODE_STORE 5'h01
`define FSP_CODE_ERASE 5'h03
`define FSP_CODE_WRITE 5'h05
`define FSP_CODE_LOCK 5'h09
`define FSP_CODE_REENABLE 5'h11

// ----------------------------------------
// command windows, in clock cycles
// ----------------------------------------
`define FSP_CNT_W 3
`define FSP_CNT_ZERO 3'h0
`define FSP_CNT_ONE 3'h1
`define FSP_STORE_LAST 3'h3
`define FSP_LOAD_LIMIT 3'h3

// ----------------------------------------
// pointer and page buffer geometry
// ----------------------------------------
`define FSP_PTR_MSB 15
`define FSP_WORD_BITS 5
`define FSP_PAGE_WORDS 32
`define FSP_PAGE_BITS 10
`define FSP_WORD_W 16
`define FSP_ERASED_WORD 16'hFFFF
`define FSP_HALT_FIRST_PAGE 10'h3C0
`define FSP_SEL_FUSE_LOW 2'h0
`define FSP_SEL_LOCK 2'h1
`define FSP_SEL_FUSE_EXT 2'h2
`define FSP_SEL_FUSE_HIGH 2'h3

`endif

/* include/fsp_pkg.sv */
package fsp_pkg;

  typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_state_type;

  typedef enum logic [1:0] {FSP_OP_NONE, FSP_OP_ERASE, FSP_OP_WRITE, FSP_OP_LOCK} fsp_op_type;

endpackage

/* verif/fsp_cpu.sv */
`timescale 1ns/10ps
module fsp_cpu (
  // system
  input wire logic clk_i,
  // instruction side
  output logic store_instr_o,
  output logic load_instr_o,
  output logic [15:0] pointer_o,
  output logic [7:0] data_low_o,
  output logic [7:0] data_high_o,
  // flash array
  input wire logic flash_start_i,
  output logic flash_done_o
);
  int done_delay = 20;

  initial begin
    store_instr_o = 1'b0;
    load_instr_o = 1'b0;
    pointer_o = 16'h0000;
    data_low_o = 8'h00;
    data_high_o = 8'h00;
    flash_done_o = 1'b0;
  end

  // ----------------------------------------
  // one instruction, issued right after the control write
  // ----------------------------------------
  // callers keep interrupts out of the timed sequence
  // erase and write pointers carry the page only
  task automatic issue(input logic ld, input logic [15:0] ptr, input logic [15:0] dat);
    @(posedge clk_i);
    store_instr_o <= !ld;
    load_instr_o <= ld;
    pointer_o <= ptr;
    {data_high_o, data_low_o} <= dat;
    @(posedge clk_i);
    store_instr_o <= 1'b0;
    load_instr_o <= 1'b0;
    // released operands flip so a late sample cannot look right
    pointer_o <= ~ptr;
    {data_high_o, data_low_o} <= ~dat;
  endtask

  // ----------------------------------------
  // flash array finishes some cycles after each start
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (flash_start_i) begin
      repeat (done_delay) @(posedge clk_i);
      flash_done_o <= 1'b1;
      @(posedge clk_i);
      flash_done_o <= 1'b0;
    end
  end
endmodule

/* verif/tb.sv */
`timescale 1ns/10ps
module tb;
  import fsp_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, eeprom_write_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic store_instr_i, load_instr_i, load_valid_o, cpu_halt_o;
  logic section_read_block_o, ready_irq_o, flash_start_o, flash_done_i;
  logic [15:0] pointer_i, buf_word_o;
  logic [7:0] data_low_register_i, data_high_register_i, load_data_o, flash_lock_data_o;
  logic [7:0] lock_bits_i, fuse_low_i, fuse_high_i, fuse_ext_i;
  fsp_op_type flash_op_o;
  logic [9:0] flash_page_o;
  logic [4:0] buf_index_i;
  logic [7:0] sel_exp [4] = '{8'h5E, 8'hA3, 8'h02, 8'hC9};
  logic [7:0] bad [4] = '{8'h07, 8'h1F, 8'h02, 8'h19};
  logic [7:0] cmds [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
  int error_cnt = 0;
  int total_checks = 0;

  fsp_ctrl fsp_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .store_instr_i(store_instr_i), .load_instr_i(load_instr_i), .pointer_i(pointer_i),
    .data_low_register_i(data_low_register_i), .data_high_register_i(data_high_register_i),
    .load_data_o(load_data_o), .load_valid_o(load_valid_o), .cpu_halt_o(cpu_halt_o),
    .section_read_block_o(section_read_block_o), .ready_irq_o(ready_irq_o),
    .eeprom_write_i(eeprom_write_i), .lock_bits_i(lock_bits_i), .fuse_low_i(fuse_low_i),
    .fuse_high_i(fuse_high_i), .fuse_ext_i(fuse_ext_i), .flash_start_o(flash_start_o),
    .flash_op_o(flash_op_o), .flash_page_o(flash_page_o),
    .flash_lock_data_o(flash_lock_data_o), .flash_done_i(flash_done_i),
    .buf_index_i(buf_index_i), .buf_word_o(buf_word_o));

  fsp_cpu fsp_cpu_i (.clk_i(clk_i), .store_instr_o(store_instr_i),
    .load_instr_o(load_instr_i), .pointer_o(pointer_i), .data_low_o(data_low_register_i),
    .data_high_o(data_high_register_i), .flash_start_i(flash_start_o),
    .flash_done_o(flash_done_i));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // settle one edge's updates before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // classic single cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    sel_i <= 4'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic wait_done();
    while (flash_op_o !== FSP_OP_NONE) @(posedge clk_i);
    tick(1);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    #2_000_000;
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    eeprom_write_i = 1'b0;
    buf_index_i = 5'h04;
    {fuse_low_i, lock_bits_i, fuse_ext_i, fuse_high_i} = {sel_exp[0], sel_exp[1], sel_exp[2],
                                                         sel_exp[3]};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    rd(8'h68, 32'h0000_0000);
    chk(buf_word_o, 16'hFFFF);
    chk(ready_irq_o, 1'b0);
    wr(8'h40, 8'hFF);
    rd(8'h40, 32'h0000_0000);
    foreach (bad[i]) begin
      wr(8'h68, bad[i]);
      rd(8'h68, 32'h0000_0000);
    end
    // page load, pointer bit zero set on purpose
    wr(8'h68, 8'h01);
    fsp_cpu_i.issue(1'b0, 16'h0009, 16'h1234);
    tick(2);
    chk(buf_word_o, 16'h1234);
    rd(8'h68, 32'h0000_0000);
    wr(8'h68, 8'h11);
    tick(1);
    chk(buf_word_o, 16'hFFFF);
    wr(8'h68, 8'h01);
    fsp_cpu_i.issue(1'b0, 16'h0008, 16'h5678);
    tick(2);
    chk(buf_word_o, 16'h5678);
    @(posedge clk_i);
    eeprom_write_i <= 1'b1;
    @(posedge clk_i);
    eeprom_write_i <= 1'b0;
    tick(1);
    chk(buf_word_o, 16'hFFFF);
    // a store one cycle after the window must do nothing
    foreach (cmds[i]) begin
      wr(8'h68, cmds[i]);
      tick(2);
      fsp_cpu_i.issue(1'b0, 16'h0148, 16'h9999);
      tick(2);
      rd(8'h68, 32'h0000_0000);
      chk(flash_op_o, FSP_OP_NONE);
      chk(buf_word_o, 16'hFFFF);
    end
    // erase of a readable page, store in the last window cycle
    wr(8'h68, 8'h03);
    tick(1);
    fsp_cpu_i.issue(1'b0, 16'h0140, 16'h0000);
    tick(2);
    chk(flash_op_o, FSP_OP_ERASE);
    chk(flash_page_o, 10'h005);
    chk(section_read_block_o, 1'b1);
    chk(cpu_halt_o, 1'b0);
    wr(8'h68, 8'h91);
    rd(8'h68, 32'h0000_00C3);
    chk(ready_irq_o, 1'b0);
    wait_done();
    rd(8'h68, 32'h0000_00C0);
    chk(ready_irq_o, 1'b1);
    wr(8'h68, 8'h91);
    fsp_cpu_i.issue(1'b0, 16'h0000, 16'h0000);
    tick(2);
    chk(section_read_block_o, 1'b0);
    rd(8'h68, 32'h0000_0080);
    // erase of a halting page
    wr(8'h68, 8'h03);
    fsp_cpu_i.issue(1'b0, 16'hF000, 16'h0000);
    tick(2);
    chk(cpu_halt_o, 1'b1);
    chk(section_read_block_o, 1'b0);
    wait_done();
    chk(cpu_halt_o, 1'b0);
    // page write drains and clears the buffer
    wr(8'h68, 8'h81);
    chk(ready_irq_o, 1'b0);
    fsp_cpu_i.issue(1'b0, 16'h0008, 16'hABCD);
    tick(2);
    chk(buf_word_o, 16'hABCD);
    chk(ready_irq_o, 1'b1);
    wr(8'h68, 8'h05);
    fsp_cpu_i.issue(1'b0, 16'h01C0, 16'h5555);
    tick(2);
    chk(flash_op_o, FSP_OP_WRITE);
    chk(flash_page_o, 10'h007);
    wait_done();
    chk(buf_word_o, 16'hFFFF);
    rd(8'h68, 32'h0000_0040);
    wr(8'h68, 8'h01);
    fsp_cpu_i.issue(1'b0, 16'h0008, 16'h1111);
    tick(1);
    rd(8'h68, 32'h0000_0000);
    // lock programming takes the low data byte only
    wr(8'h68, 8'h09);
    fsp_cpu_i.issue(1'b0, 16'hFFFF, 16'h77A5);
    tick(1);
    chk(flash_op_o, FSP_OP_LOCK);
    chk(flash_lock_data_o, 8'hA5);
    wait_done();
    rd(8'h68, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      wr(8'h68, 8'h09);
      fsp_cpu_i.issue(1'b1, 16'(s), 16'h0000);
      #1;
      chk(load_valid_o, 1'b1);
      chk(load_data_o, sel_exp[s]);
      tick(1);
      rd(8'h68, 32'h0000_0000);
    end
    // loads without lock set, or in the last window cycle, return nothing
    wr(8'h68, 8'h01);
    fsp_cpu_i.issue(1'b1, 16'h0001, 16'h0000);
    #1;
    chk(load_valid_o, 1'b0);
    wr(8'h68, 8'h09);
    tick(1);
    fsp_cpu_i.issue(1'b1, 16'h0001, 16'h0000);
    #1;
    chk(load_valid_o, 1'b0);
    tick(1);
    rd(8'h68, 32'h0000_0000);
    // a reset in mid-run empties the buffer
    chk(buf_word_o, 16'h1111);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    chk(buf_word_o, 16'hFFFF);
    rd(8'h68, 32'h0000_0000);
    end_of_test();
  end
endmodule
